// file: src/pms_core.sv
// Module: PHY-side COL/CRS/speed status, hardware reset, MDC timing and register slave
// Operation
// - Speed pin low 10M, high 100M
// - Low reset pin holds device in reset
// - COL when receiving during own transmit
// - 10M receive activity from unsquelched signal
// - 100M activity: symbol with non-adjacent zeros
// - COL unrelated to receive/transmit clocks
// - Full duplex forces COL low
// - SQE test asserts COL unless inhibited (here only after 10M transmissions, not full duplex)
// - Half duplex CRS on receive or transmit
// - Full duplex or repeater: CRS receive only
// - CRS unrelated to receive/transmit clocks
// - MDIO transfers timed by incoming MDC
// - MDIO launched and sampled with MDC
// - LED pins are straps during reset
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pms_core #(
  parameter int SQE_LEN = pms_pkg::SQE_CYCLES  // Length of SQE pulse in clocks
) (
  input  wire logic        clk,                // 50 MHz clock
  input  wire logic        rst,                // Synchronous reset, active high
  input  wire logic        hardware_reset_low, // Reset pin, active low
  input  wire logic [4:0]  address,            // Avalon byte address
  input  wire logic        read,               // Avalon read
  input  wire logic        write,              // Avalon write
  input  wire logic [31:0] writedata,          // Avalon write data
  input  wire logic [3:0]  byteenable,         // Avalon byte enables
  output logic      [31:0] readdata,           // Avalon read data
  output logic             waitrequest,        // Avalon wait request
  output logic             irq,                // Level interrupt
  input  wire logic        txen,               // Transmit enable from MAC
  input  wire logic        rx_unsquelched,     // 10M medium receive level
  input  wire logic [9:0]  rx_symbol,          // 100M received symbol
  input  wire logic        rx_symbol_valid,    // Symbol strobe
  input  wire logic        link_up,            // Link status for LED
  output logic             col,                // Collision
  output logic             crs,                // Carrier sense
  output logic             speed_100,          // Speed indicator
  input  wire logic        mdc,                // Management clock in
  input  wire logic        mdio_i,             // MDIO pin level
  output logic             mdio_o,             // MDIO drive value
  output logic             mdio_oe_n,          // MDIO enable, low drives
  input  wire logic [2:0]  led_i,              // Strap/LED pin levels
  output logic      [2:0]  led_o,              // LED drive values
  output logic      [2:0]  led_oe_n            // LED enables, low drives
);

  // Elaboration check: the pulse counter is 13 bits wide
  if (SQE_LEN < 1 || SQE_LEN > 4096)
  begin : g_bad_len
    $error("SQE_LEN out of range");
  end

  // Non-adjacent zero pair anywhere in a symbol
  function automatic logic nonadj_zeros(input logic [pms_pkg::SYM_W-1:0] s);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < pms_pkg::SYM_W; i++)
      for (int j = i + 2; j < pms_pkg::SYM_W; j++)
        if (!s[i] && !s[j])
          hit = 1'b1;
    return hit;
  endfunction

  // Merge write data under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset
  logic rst_all;
  assign rst_all = rst | ~hardware_reset_low;

  ////////////////////////////////////////////////////////////////////////////
  // Register slave
  logic [pms_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [pms_pkg::IRQ_W-1:0]  istat_q, istat_d, imask_q, imask_d;
  logic [pms_pkg::MDIO_W-1:0] mtx_q, mtx_d;
  logic [31:0]                rdata_q, rdata_d;
  logic                       wait_q, wait_d, irq_q, irq_d;
  logic                       req, wr_go;
  logic [pms_pkg::IRQ_W-1:0]  ev;
  logic [31:0]                rmux;
  pms_pkg::pms_ctrl_s         cf;
  logic [pms_pkg::MDIO_W-1:0] mrx_q;
  logic [2:0]                 strap_q;
  logic                       col_q, crs_q, speed_q;
  logic                       mload;
  logic                       mdone;

  assign cf    = pms_pkg::pms_ctrl_s'(ctrl_q);
  assign req   = read | write;
  assign wr_go = write & ~wait_q;  // Write lands at the edge waitrequest is low

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rmux = 32'h0000_0000;
    case (address)
      pms_pkg::OFF_CTRL:     rmux[pms_pkg::CTRL_W-1:0] = ctrl_q;
      pms_pkg::OFF_STATUS:   rmux[2:0] = {speed_q, crs_q, col_q};
      pms_pkg::OFF_IRQ_STAT: rmux[pms_pkg::IRQ_W-1:0] = istat_q;
      pms_pkg::OFF_IRQ_MASK: rmux[pms_pkg::IRQ_W-1:0] = imask_q;
      pms_pkg::OFF_MDIO_RX:  rmux = mrx_q;
      pms_pkg::OFF_MDIO_TX:  rmux = mtx_q;
      pms_pkg::OFF_STRAP:    rmux[2:0] = strap_q;
      default:               rmux = 32'h0000_0000;
    endcase
  end

  // Next register values; hardware set wins over write-one clear
  always_comb
  begin
    wait_d  = ~(req & wait_q);
    rdata_d = (read & wait_q) ? rmux : rdata_q;
    ctrl_d  = ctrl_q;
    imask_d = imask_q;
    mtx_d   = mtx_q;
    mload   = 1'b0;
    istat_d = istat_q;
    if (wr_go)
    begin
      case (address)
        pms_pkg::OFF_CTRL:     ctrl_d  = (pms_pkg::CTRL_W)'(be_merge(32'(ctrl_q), writedata, byteenable));
        pms_pkg::OFF_IRQ_MASK: imask_d = (pms_pkg::IRQ_W)'(be_merge(32'(imask_q), writedata, byteenable));
        pms_pkg::OFF_IRQ_STAT: istat_d = istat_q & ~(writedata[pms_pkg::IRQ_W-1:0] & {pms_pkg::IRQ_W{byteenable[0]}});
        pms_pkg::OFF_MDIO_TX:
        begin
          mtx_d = be_merge(mtx_q, writedata, byteenable);
          mload = 1'b1;
        end
        default: ;
      endcase
    end
    istat_d = istat_d | ev;
    irq_d   = |(istat_d & imask_d);
  end

  // Register update
  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
      ctrl_q  <= pms_pkg::CTRL_RESET;
      imask_q <= pms_pkg::MASK_RESET;
      istat_q <= '0;
      mtx_q   <= '0;
      irq_q   <= 1'b0;
    end
    else
    begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      ctrl_q  <= ctrl_d;
      imask_q <= imask_d;
      istat_q <= istat_d;
      mtx_q   <= mtx_d;
      irq_q   <= irq_d;
    end
  end

  assign readdata    = rdata_q;
  assign waitrequest = wait_q;
  assign irq         = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Receive activity and SQE test
  pms_pkg::pms_act_s act;
  logic              rx100_q, rx100_d;
  pms_pkg::pms_sqe_e sqe_q, sqe_d;
  logic [12:0]       sqe_cnt_q, sqe_cnt_d;
  logic              col_d, crs_d, speed_d;

  // Activity per mode; the 100M result holds between symbols
  always_comb
  begin
    rx100_d = rx_symbol_valid ? nonadj_zeros(rx_symbol) : rx100_q;
    act.tx  = txen;
    act.rx  = cf.speed_100 ? rx100_q : rx_unsquelched;
  end

  // SQE pulse after each uninhibited 10M half-duplex transmission, cut short by a new transmission
  always_comb
  begin
    sqe_d     = sqe_q;
    sqe_cnt_d = sqe_cnt_q;
    case (sqe_q)
      pms_pkg::SQE_IDLE:
        if (act.tx)
          sqe_d = pms_pkg::SQE_TX;
      pms_pkg::SQE_TX:
        if (!act.tx)
        begin
          if (cf.sqe_inhibit || cf.full_duplex || cf.speed_100)
            sqe_d = pms_pkg::SQE_IDLE;
          else
          begin
            sqe_d     = pms_pkg::SQE_PULSE;
            sqe_cnt_d = 13'(SQE_LEN - 1);
          end
        end
      pms_pkg::SQE_PULSE:
        if (act.tx)
          sqe_d = pms_pkg::SQE_TX;
        else if (sqe_cnt_q == 13'h0000)
          sqe_d = pms_pkg::SQE_IDLE;
        else
          sqe_cnt_d = sqe_cnt_q - 13'h0001;
      default: sqe_d = pms_pkg::SQE_IDLE;
    endcase
  end

  // COL, CRS and speed, registered every clock so they fall one clock after their cause ends
  always_comb
  begin
    speed_d = cf.speed_100;
    col_d   = ((act.rx & act.tx) | (sqe_q == pms_pkg::SQE_PULSE)) & ~cf.full_duplex;
    if (cf.full_duplex || cf.repeater)
      crs_d = act.rx;
    else
      crs_d = act.rx | act.tx;
    ev                       = '0;
    ev[pms_pkg::IRQ_COL_BIT] = col_d & ~col_q;
    ev[pms_pkg::IRQ_CRS_BIT] = crs_d & ~crs_q;
    ev[pms_pkg::IRQ_MDIO_BIT] = mdone;
  end

  // COL and CRS run on the system clock, not the MII clocks; the MAC must synchronise them
  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      rx100_q   <= 1'b0;
      sqe_q     <= pms_pkg::SQE_IDLE;
      sqe_cnt_q <= 13'h0000;
      col_q     <= 1'b0;
      crs_q     <= 1'b0;
      speed_q   <= 1'b0;
    end
    else
    begin
      rx100_q   <= rx100_d;
      sqe_q     <= sqe_d;
      sqe_cnt_q <= sqe_cnt_d;
      col_q     <= col_d;
      crs_q     <= crs_d;
      speed_q   <= speed_d;
    end
  end

  assign col       = col_q;
  assign crs       = crs_q;
  assign speed_100 = speed_q;

  ////////////////////////////////////////////////////////////////////////////
  // MDC edge detect and MDIO shifting; MDC is only ever an input here
  logic       mdc_q, mdo_q, mdo_d, mdoe_q, mdoe_d;
  logic [pms_pkg::MDIO_W-1:0] mrx_d, msh_q, msh_d;
  logic [5:0] mcnt_q, mcnt_d;
  logic       mrise, mfall;

  assign mrise = mdc & ~mdc_q;
  assign mfall = ~mdc & mdc_q;

  // Sample on MDC rise, launch on MDC fall
  always_comb
  begin
    mrx_d  = mrx_q;
    msh_d  = msh_q;
    mcnt_d = mcnt_q;
    mdo_d  = mdo_q;
    mdoe_d = ~cf.mdio_drive;
    mdone  = 1'b0;
    if (mrise)
    begin
      mrx_d = {mrx_q[pms_pkg::MDIO_W-2:0], mdio_i};
      if (mcnt_q == 6'(pms_pkg::MDIO_W - 1))
      begin
        mcnt_d = 6'h00;
        mdone  = 1'b1;
      end
      else
        mcnt_d = mcnt_q + 6'h01;
    end
    if (mload)
      msh_d = mtx_d;
    else if (mfall)
    begin
      mdo_d = msh_q[pms_pkg::MDIO_W-1];
      msh_d = {msh_q[pms_pkg::MDIO_W-2:0], 1'b0};
    end
  end

  // MDIO registers
  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      mdc_q  <= 1'b0;
      mrx_q  <= '0;
      msh_q  <= '0;
      mcnt_q <= 6'h00;
      mdo_q  <= 1'b0;
      mdoe_q <= 1'b1;
    end
    else
    begin
      mdc_q  <= mdc;
      mrx_q  <= mrx_d;
      msh_q  <= msh_d;
      mcnt_q <= mcnt_d;
      mdo_q  <= mdo_d;
      mdoe_q <= mdoe_d;
    end
  end

  assign mdio_o    = mdo_q;
  assign mdio_oe_n = mdoe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Strap pins: inputs during reset, LED outputs after
  logic [2:0] strap_d, ledo_q, ledo_d, ledoe_q;

  // Strap keeps following the pins while either reset is held
  always_comb
  begin
    strap_d = rst_all ? led_i : strap_q;
    ledo_d  = {act.rx, act.tx, link_up};
  end

  // Strap capture is clocked, not tied to the reset branch
  always_ff @(posedge clk)
  begin
    strap_q <= strap_d;
    if (rst_all)
    begin
      ledo_q  <= 3'h0;
      ledoe_q <= 3'h7;
    end
    else
    begin
      ledo_q  <= ledo_d;
      ledoe_q <= 3'h0;
    end
  end

  assign led_o    = ledo_q;
  assign led_oe_n = ledoe_q;

endmodule

`default_nettype wire

// file: src/pms_pkg.sv
// Package: constants and types for the PHY MII status and reset block
package pms_pkg;

  // Register byte offsets
  localparam logic [4:0] OFF_CTRL     = 5'h00;
  localparam logic [4:0] OFF_STATUS   = 5'h04;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h08;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h0C;
  localparam logic [4:0] OFF_MDIO_RX  = 5'h10;
  localparam logic [4:0] OFF_MDIO_TX  = 5'h14;
  localparam logic [4:0] OFF_STRAP    = 5'h18;

  // Control field positions
  localparam int CTRL_SPEED_BIT  = 0;
  localparam int CTRL_FDX_BIT    = 1;
  localparam int CTRL_RPT_BIT    = 2;
  localparam int CTRL_SQEINH_BIT = 3;
  localparam int CTRL_MDRV_BIT   = 4;
  localparam int CTRL_W          = 5;

  // Interrupt status field positions
  localparam int IRQ_COL_BIT  = 0;
  localparam int IRQ_CRS_BIT  = 1;
  localparam int IRQ_MDIO_BIT = 2;
  localparam int IRQ_W        = 3;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam logic [IRQ_W-1:0]  MASK_RESET = 3'h0;

  // Timing: clock rate and length of the SQE test pulse on COL
  localparam int CLK_PERIOD_NS = 20;
  localparam int SQE_TIME_NS   = 1000;
  localparam int SQE_CYCLES    = (SQE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Management shift width and symbol width
  localparam int MDIO_W = 32;
  localparam int SYM_W  = 10;

  // Control fields as software sets them
  typedef struct packed {
    logic mdio_drive;
    logic sqe_inhibit;
    logic repeater;
    logic full_duplex;
    logic speed_100;
  } pms_ctrl_s;

  // Live activity seen by the status logic
  typedef struct packed {
    logic tx;
    logic rx;
  } pms_act_s;

  // State of the SQE test pulse
  typedef enum logic [1:0] {
    SQE_IDLE,
    SQE_TX,
    SQE_PULSE
  } pms_sqe_e;

endpackage

// file: verification/pms_core_asserts.sv
// Checker: timing relations of the status pins and the bus of pms_core
`timescale 1ns/1ps
`default_nettype none

module pms_core_asserts #(
  parameter int SQE_LEN = pms_pkg::SQE_CYCLES  // SQE pulse length
) (
  input wire logic        clk,                // Clock
  input wire logic        rst,                // Sync reset
  input wire logic        hardware_reset_low, // Reset pin
  input wire logic [4:0]  address,            // Bus address
  input wire logic        write,              // Bus write
  input wire logic [31:0] writedata,          // Bus data
  input wire logic [3:0]  byteenable,         // Byte lanes
  input wire logic        waitrequest,        // Bus stall
  input wire logic        txen,               // Transmit enable
  input wire logic        rx_unsquelched,     // 10M receive
  input wire logic        col,                // Collision
  input wire logic        crs,                // Carrier
  input wire logic        speed_100,          // Speed pin
  input wire logic [2:0]  led_oe_n            // LED enables
);
  localparam int SQE_LAST = SQE_LEN - 1;
  logic [4:0] ctrl_d;
  logic [4:0] ctrl_q;
  wire        in_rst   = rst || !hardware_reset_low;
  wire        half     = ctrl_q[2:1] == 2'h0;
  wire        m10      = !ctrl_q[0];
  wire        sqe_on   = ctrl_q[3:0] == 4'h0;
  wire        ovl      = half && m10 && txen && rx_unsquelched;
  wire        rx_idle  = !half && m10 && !rx_unsquelched;
  wire        inh_idle = ctrl_q[3] && !txen;

  ////////////////////////////////////////////////////////////
  // Control shadow; moves only at the edge that accepts a write
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (write && !waitrequest && address == pms_pkg::OFF_CTRL && byteenable[0])
      ctrl_d = writedata[4:0];
  end

  always_ff @(posedge clk)
    ctrl_q <= in_rst ? 5'h00 : ctrl_d;

  default clocking cb @(posedge clk); endclocking
  default disable iff (in_rst);

  // SQE pulse may start one or two cycles late, so both starts are allowed
  sequence s_sqe_start;
    $fell(txen) && sqe_on && $past(sqe_on);
  endsequence
  sequence s_sqe_pulse;
    col ##SQE_LAST col ##1 !col;
  endsequence

  ////////////////////////////////////////////////////////////
  a_sqe_pulse: assert property (s_sqe_start |-> ##[1:2] s_sqe_pulse)
    else $error("SQE pulse wrong length");
  a_speed_track: assert property (speed_100 == $past(ctrl_q[0]))
    else $error("Speed pin off mode");
  a_fdx_col_low: assert property (ctrl_q[1] && $past(ctrl_q[1]) && $past(ctrl_q[1], 2) |-> !col)
    else $error("Collision in full duplex");
  a_col_cause: assert property ($rose(col) |-> $past(txen) || $past(txen, 2) || $past(txen, 3))
    else $error("Collision without transmit");
  a_col_overlap: assert property ($past(ovl) |-> col)
    else $error("Overlap without collision");
  a_col_release: assert property ($past(inh_idle) |-> !col)
    else $error("Collision held after transmit");
  a_crs_on_tx: assert property ($past(half) && $past(txen) |-> crs)
    else $error("No carrier on transmit");
  a_crs_rx_only: assert property ($past(rx_idle) && $past(m10, 2) |-> !crs)
    else $error("Carrier from own transmit");
  a_led_output: assert property (!$past(in_rst) |-> led_oe_n == 3'h0)
    else $error("LED pins not driven");
endmodule

bind pms_core pms_core_asserts #(.SQE_LEN(SQE_LEN)) u_pms_core_asserts (
  .clk, .rst, .hardware_reset_low, .address, .write, .writedata, .byteenable,
  .waitrequest, .txen, .rx_unsquelched, .col, .crs, .speed_100, .led_oe_n);

`default_nettype wire

// file: verification/pms_sta_model.sv
// Partner: station management entity that sources MDC and serial frames
`timescale 1ns/1ps
`default_nettype none

module pms_sta_model (
  input  wire logic        clk,       // Bench clock
  input  wire logic        start,     // Begin a frame
  input  wire logic        drive,     // Drive data, else release
  input  wire logic [31:0] tx_word,   // Word to send
  input  wire logic        mdio_o,    // Device drive value
  input  wire logic        mdio_oe_n, // Device enable, low drives
  output logic             mdc,       // Management clock
  output logic             mdio_line, // Resolved line level
  output logic             busy,      // Frame running
  output logic      [31:0] rx_word    // Last bits sampled
);
  logic bit_q = 1'h0;
  logic drv_q = 1'h0;

  initial
  begin
    mdc = 1'h0;
    busy = 1'h0;
    rx_word = 32'h0;
  end

  // Released line floats to the pull-up level, never the last value
  assign mdio_line = !mdio_oe_n ? mdio_o : (drv_q ? bit_q : 1'h1);

  ////////////////////////////////////////////////////////////
  // MDC idles low; 33 rises so the first, before any fall, carries no data
  always @(posedge clk)
  begin
    if (start && !busy)
    begin
      busy <= 1'h1;
      drv_q <= drive;
      for (int k = 0; k < 33; k++)
      begin
        bit_q <= (k == 0) ? 1'h0 : tx_word[(32 - k) & 31];
        repeat (4) @(posedge clk);
        mdc <= 1'h1;
        rx_word <= {rx_word[30:0], mdio_line};
        repeat (4) @(posedge clk);
        mdc <= 1'h0;
      end
      drv_q <= 1'h0;
      busy <= 1'h0;
    end
  end
endmodule

`default_nettype wire

// file: verification/pms_core_bench.sv
// Testbench: corner and random stimulus for pms_core with a management partner
`timescale 1ns/1ps
`default_nettype none

module pms_core_bench;
  localparam int SQE_LEN = 4;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        hardware_reset_low = 1'h1;
  logic [4:0]  address = 5'h00;
  logic        read = 1'h0;
  logic        write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic        txen = 1'h0;
  logic        rx_unsquelched = 1'h0;
  logic [9:0]  rx_symbol = 10'h3FF;
  logic        rx_symbol_valid = 1'h0;
  logic [2:0]  led_i = 3'h5;
  logic        sta_start = 1'h0;
  logic        sta_drive = 1'h0;
  logic [31:0] sta_tx = 32'h0;
  logic [31:0] seed = 32'h22;
  logic [31:0] readdata, sta_rx, rd, word;
  logic        waitrequest, irq, col, crs, speed_100, mdc, mdio_line, mdio_o, mdio_oe_n, sta_busy;
  logic [2:0]  led_oe_n, led_o;
  logic [9:0]  sym;
  logic [15:0] tbl [4] = '{16'h0111, 16'h8110, 16'h2000, 16'h4012};
  logic [9:0]  corner [4] = '{10'h3FF, 10'h3FC, 10'h3F6, 10'h1FE};
  int          err_count = 0;
  int          checks_done = 0;
  int          n;

  always #10 clk = ~clk;

  pms_core #(.SQE_LEN(SQE_LEN)) u_pms_core (
    .clk, .rst, .hardware_reset_low, .address, .read, .write, .writedata, .byteenable(4'hF),
    .readdata, .waitrequest, .irq, .txen, .rx_unsquelched, .rx_symbol, .rx_symbol_valid,
    .link_up(1'h0), .col, .crs, .speed_100, .mdc, .mdio_i(mdio_line), .mdio_o, .mdio_oe_n,
    .led_i, .led_o, .led_oe_n);

  pms_sta_model u_pms_sta_model (
    .clk, .start(sta_start), .drive(sta_drive), .tx_word(sta_tx), .mdio_o, .mdio_oe_n,
    .mdc, .mdio_line, .busy(sta_busy), .rx_word(sta_rx));

  ////////////////////////////////////////////////////////////
  // Expectation helpers: random source and 100M activity rule
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic act(input logic [9:0] s);
    act = 1'h0;
    for (int i = 0; i < 10; i++)
      for (int j = i + 2; j < 10; j++)
        if (!s[i] && !s[j])
          act = 1'h1;
  endfunction

  // Compare, count and report
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  // One bus cycle; held until waitrequest is sampled low, then one idle edge
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] wd);
    n = 0;
    address <= a;
    writedata <= wd;
    write <= we;
    read <= !we;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'h0 && n < 20);
    rd = readdata;
    read <= 1'h0;
    write <= 1'h0;
    check("bus_answer", waitrequest, 1'h0);
    @(posedge clk);
  endtask

  task automatic end_of_test;
    $display("Mismatches %0d in %0d checks", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    tick(1);
    led_i <= 3'h0;
    bus(1'h0, pms_pkg::OFF_STRAP, 32'h0);
    check("strap", rd, 32'h5);
    check("led_oe_n", led_oe_n, 3'h0);
    bus(1'h1, pms_pkg::OFF_IRQ_MASK, 32'h1);
    // 10M modes: half, inhibited, full duplex, repeater
    for (int i = 0; i < 4; i++)
    begin
      bus(1'h1, pms_pkg::OFF_CTRL, {28'h0, tbl[i][15:12]});
      bus(1'h1, pms_pkg::OFF_IRQ_STAT, 32'h7);
      tick(1);
      check("irq_clear", irq, 1'h0);
      txen <= 1'h1;
      tick(2);
      check("crs_tx", crs, tbl[i][8]);
      rx_unsquelched <= 1'h1;
      tick(2);
      check("col", col, tbl[i][4]);
      rx_unsquelched <= 1'h0;
      tick(2);
      check("col_end", col, 1'h0);
      check("irq", irq, tbl[i][4]);
      txen <= 1'h0;
      n = 0;
      repeat (12)
      begin
        @(posedge clk);
        n += col;
      end
      if (!tbl[i][1])
        check("sqe_len", n, tbl[i][0] ? SQE_LEN : 0);
      check("crs_end", crs, 1'h0);
    end
    // 100M half duplex with corner and random symbols, interrupt masked
    bus(1'h1, pms_pkg::OFF_IRQ_MASK, 32'h0);
    bus(1'h1, pms_pkg::OFF_CTRL, 32'h1);
    tick(1);
    check("speed_100", speed_100, 1'h1);
    txen <= 1'h1;
    for (int i = 0; i < 25; i++)
    begin
      seed = xs(seed);
      sym = (i < 4) ? corner[i] : (i == 24) ? 10'h3FF : seed[9:0];
      rx_symbol <= sym;
      rx_symbol_valid <= 1'h1;
      tick(1);
      rx_symbol_valid <= 1'h0;
      tick(3);
      check("col_100", col, act(sym));
      check("led_100", led_o, {act(sym), 2'h2});
    end
    txen <= 1'h0;
    tick(12);
    check("crs_100_end", crs, 1'h0);
    check("col_100_end", col, 1'h0);
    check("irq_masked", irq, 1'h0);
    bus(1'h0, pms_pkg::OFF_IRQ_STAT, 32'h0);
    check("irq_stat", rd[0], 1'h1);
    // Management frames: device samples, then device drives
    for (int m = 0; m < 2; m++)
    begin
      word = xs(seed);
      seed = word;
      sta_tx <= word;
      sta_drive <= (m == 0);
      bus(1'h1, pms_pkg::OFF_CTRL, (m == 0) ? 32'h0 : 32'h10);
      bus(1'h1, pms_pkg::OFF_MDIO_TX, word);
      check("speed_10", speed_100, 1'h0);
      check("mdio_oe_n", mdio_oe_n, m == 0);
      sta_start <= 1'h1;
      tick(1);
      sta_start <= 1'h0;
      tick(1);
      n = 0;
      while (sta_busy === 1'h1 && n < 400)
      begin
        tick(1);
        n++;
      end
      bus(1'h0, pms_pkg::OFF_MDIO_RX, 32'h0);
      check("mdio_word", (m == 0) ? rd : sta_rx, word);
    end
    bus(1'h0, pms_pkg::OFF_IRQ_STAT, 32'h0);
    check("irq_mdio", rd[2], 1'h1);
    // Hardware reset pin in mid-run
    bus(1'h1, pms_pkg::OFF_CTRL, 32'h1);
    hardware_reset_low <= 1'h0;
    led_i <= 3'h2;
    tick(3);
    check("speed_rst", speed_100, 1'h0);
    check("led_oe_rst", led_oe_n, 3'h7);
    hardware_reset_low <= 1'h1;
    tick(1);
    bus(1'h0, pms_pkg::OFF_STRAP, 32'h0);
    check("strap_rst", rd, 32'h2);
    bus(1'h0, pms_pkg::OFF_CTRL, 32'h0);
    check("ctrl_rst", rd, 32'h0);
    bus(1'h0, 5'h1C, 32'h0);
    check("unmapped", rd, 32'h0);
    end_of_test();
  end

  // Watchdog well beyond the expected run of about 800 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    end_of_test();
  end
endmodule

`default_nettype wire
